// ### ufd_map.svh
// Offsets, reset values, field positions and counts of the user format
// register bank. Definitions only; included by every file that needs them.
`ifndef UFD_MAP_SVH
`define UFD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UFD_OFF_F3_RST_HI   8'h47
`define UFD_OFF_F3_RST_LO   8'h48
`define UFD_OFF_AUD_FSEQ    8'h49
`define UFD_OFF_AUD_CLKSEL  8'h4a
`define UFD_OFF_RESERVED_GAP_FIRST  8'h4b
`define UFD_OFF_RESERVED_GAP_LAST   8'h50
`define UFD_OFF_CMAX_HI     8'h51
`define UFD_OFF_CMAX_LO     8'h52
`define UFD_OFF_CMIN_HI     8'h53
`define UFD_OFF_CMIN_LO     8'h54
`define UFD_OFF_RDIV_HI     8'h55
`define UFD_OFF_RDIV_LO     8'h56
`define UFD_OFF_FDIV_HI     8'h57
`define UFD_OFF_FDIV_LO     8'h58
`define UFD_OFF_PUMP        8'h59
`define UFD_OFF_LPF_HI      8'h5a
`define UFD_OFF_LPF_LO      8'h5b
`define UFD_OFF_USR_AFS     8'h5c
`define UFD_OFF_MISC        8'h5d

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UFD_RST_F3_HI       5'h00
`define UFD_RST_F3_LO       8'h01
`define UFD_RST_AUD_FSEQ    8'h05
`define UFD_RST_AUD_CLKSEL  4'hb
`define UFD_RST_ZERO8       8'h00

// ----------------------------------------
// Misc register fields
// ----------------------------------------
`define UFD_MISC_EN_BIT     7
`define UFD_MISC_ILACE_BIT  4
`define UFD_MISC_CODE_HI    3
`define UFD_MISC_CODE_LO    0

// ----------------------------------------
// Measurement
// ----------------------------------------
`define UFD_REF_MHZ         27
`define UFD_HSYNC_PERIODS   5'd20
`define UFD_VS_CODE_LAST    4'h7

`endif

// ### ufd_pkg.sv
// Types shared by the user format detect register bank and its meter.
// Assumes ufd_map.svh is on the include path.
`default_nettype none
package ufd_pkg;

    typedef enum logic {
        UFD_MEAS_WAIT,
        UFD_MEAS_COUNT
    } ufd_meas_e;

    typedef logic [15:0] ufd_count_t;
    typedef logic [13:0] ufd_rate_t;

endpackage
`default_nettype wire

// ### ufd_hsync_meter.sv
// Counts 27 MHz reference edges over a window of Hsync periods.
// Both inputs are pins from other clock domains; they are resynchronised.
`timescale 1ns/1ps
`default_nettype none
`include "ufd_map.svh"

module ufd_hsync_meter (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Pins
    input  wire logic              ref27_pin,
    input  wire logic              hsync_pin,
    // Result
    output ufd_pkg::ufd_count_t    meas_count,
    output logic                   meas_valid
);

    logic [2:0]          ref_sync;
    logic [2:0]          hs_sync;
    logic                ref_level;
    logic                hs_level;
    logic                ref_edge;
    logic                hs_edge;
    ufd_pkg::ufd_meas_e  state;
    ufd_pkg::ufd_count_t cycles;
    logic [4:0]          periods;
    wire                 last_period;
    wire                 cycles_full;
    ufd_pkg::ufd_count_t cycles_inc;

    // ----------------------------------------
    // Pin resynchronisers
    // ----------------------------------------
    // A level only moves once stages two and three agree
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_sync  <= 3'h0;
            hs_sync   <= 3'h0;
            ref_level <= 1'b0;
            hs_level  <= 1'b0;
        end else begin
            ref_sync  <= {ref_sync[1:0], ref27_pin};
            hs_sync   <= {hs_sync[1:0], hsync_pin};
            if (ref_sync[1] == ref_sync[2]) ref_level <= ref_sync[2];
            if (hs_sync[1] == hs_sync[2]) hs_level <= hs_sync[2];
        end
    end

    assign ref_edge = (ref_sync[1] == ref_sync[2]) && ref_sync[2] && !ref_level;
    assign hs_edge  = (hs_sync[1] == hs_sync[2]) && hs_sync[2] && !hs_level;

    // ----------------------------------------
    // Window counter
    // ----------------------------------------
    assign last_period = (periods == (`UFD_HSYNC_PERIODS - 5'd1));
    assign cycles_full = (cycles == 16'hffff);
    // Saturate so a very slow Hsync never wraps into the window
    assign cycles_inc  = (ref_edge && !cycles_full) ? cycles + 16'h0001
                                                    : cycles;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= ufd_pkg::UFD_MEAS_WAIT;
            cycles     <= 16'h0000;
            periods    <= 5'h00;
            meas_count <= 16'h0000;
            meas_valid <= 1'b0;
        end else begin
            meas_valid <= 1'b0;
            case (state)
                ufd_pkg::UFD_MEAS_WAIT: begin
                    if (hs_edge) begin
                        state   <= ufd_pkg::UFD_MEAS_COUNT;
                        cycles  <= 16'h0000;
                        periods <= 5'h00;
                    end
                end
                ufd_pkg::UFD_MEAS_COUNT: begin
                    if (hs_edge && last_period) begin
                        meas_count <= cycles_inc;
                        meas_valid <= 1'b1;
                        cycles     <= 16'h0000;
                        periods    <= 5'h00;
                    end else begin
                        cycles <= cycles_inc;
                        if (hs_edge) periods <= periods + 5'd1;
                    end
                end
                default: state <= ufd_pkg::UFD_MEAS_WAIT;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    window_length_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        meas_valid |-> $past(periods) == (`UFD_HSYNC_PERIODS - 5'd1)
                       && $past(hs_edge) && periods == 5'h00)
        else $error("measurement window not twenty Hsync periods");

endmodule
`default_nettype wire

// ### ufd_regs.sv
// User format detect register bank with the top-of-frame settings that
// sit just before it in the map. Assumes a byte register port fed by the
// device's serial slave front end, and built-in format values from the
// format lookup that lives outside this block.
`timescale 1ns/1ps
`default_nettype none
`include "ufd_map.svh"

module ufd_regs #(
    parameter int         FMT_SEL_W = 5,
    parameter logic [4:0] USER_CODE = 5'h1f
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr_en,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_rd_en,
    output logic [7:0]                reg_rdata,
    // Pins
    input  wire logic                 ref27_pin,
    input  wire logic                 hsync_pin,
    // Observed input and format selection
    input  wire logic                 input_interlaced,
    input  wire logic [FMT_SEL_W-1:0] input_format_select,
    // Built-in format values
    input  wire logic                 fmt_interlaced,
    input  wire logic [3:0]           fmt_vsync_code,
    input  wire logic                 fmt_load,
    input  wire logic [12:0]          fmt_frame3_reset,
    input  wire logic [9:0]           fmt_ref_divider,
    input  wire logic [14:0]          fmt_fb_divider,
    input  wire logic [7:0]           fmt_pump_current,
    input  wire logic [12:0]          fmt_lines_per_frame,
    input  wire logic [7:0]           fmt_audio_frame_seq,
    // Lookup outputs
    output logic                      lut_interlaced,
    output logic [3:0]                input_vsync_code,
    output ufd_pkg::ufd_rate_t        input_rate_centihz,
    // Detection
    output logic                      user_format_detected,
    output ufd_pkg::ufd_count_t       hsync_meas_count,
    // Applied top-of-frame and PLL settings
    output logic [12:0]               frame3_reset_count,
    output logic [7:0]                audio_frame_seq,
    output logic [3:0]                audio_clock_select,
    output logic [9:0]                pll1_ref_divider,
    output logic [14:0]               pll1_fb_divider,
    output logic [7:0]                pll1_pump_current,
    output logic [12:0]               top_of_frame_lines,
    output logic [7:0]                top_of_frame_audio_seq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] off);
        hit = reg_wr_en && (reg_addr == off);
    endfunction

    // Rates in hundredths of a hertz; unassigned codes give zero
    function automatic ufd_pkg::ufd_rate_t rate_of(input logic [3:0] code);
        case (code)
            4'h0:    rate_of = 14'd2398;
            4'h1:    rate_of = 14'd2400;
            4'h2:    rate_of = 14'd2500;
            4'h3:    rate_of = 14'd2997;
            4'h4:    rate_of = 14'd3000;
            4'h5:    rate_of = 14'd5000;
            4'h6:    rate_of = 14'd5994;
            4'h7:    rate_of = 14'd6000;
            default: rate_of = 14'd0;
        endcase
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [4:0]          f3_rst_hi;
    logic [7:0]          f3_rst_lo;
    logic [7:0]          cmax_hi;
    logic [7:0]          cmax_lo;
    logic [7:0]          cmin_hi;
    logic [7:0]          cmin_lo;
    logic [1:0]          rdiv_hi;
    logic [7:0]          rdiv_lo;
    logic [6:0]          fdiv_hi;
    logic [7:0]          fdiv_lo;
    logic [7:0]          pump;
    logic [4:0]          lpf_hi;
    logic [7:0]          lpf_lo;
    logic [7:0]          usr_afs;
    logic                user_mode_enable;
    logic                user_interlace_flag;
    logic [3:0]          user_vsync_code;
    ufd_pkg::ufd_count_t meas_count;
    logic                meas_valid;

    wire [15:0] user_count_max = {cmax_hi, cmax_lo};
    wire [15:0] user_count_min = {cmin_hi, cmin_lo};
    wire [7:0]  misc_value     = {user_mode_enable, 2'b00,
                                  user_interlace_flag, user_vsync_code};

    // ----------------------------------------
    // Hsync measurement
    // ----------------------------------------
    ufd_hsync_meter u_meter (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .ref27_pin  (ref27_pin),
        .hsync_pin  (hsync_pin),
        .meas_count (meas_count),
        .meas_valid (meas_valid)
    );

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            audio_frame_seq    <= `UFD_RST_AUD_FSEQ;
            audio_clock_select <= `UFD_RST_AUD_CLKSEL;
            cmax_hi            <= `UFD_RST_ZERO8;
            cmax_lo            <= `UFD_RST_ZERO8;
            cmin_hi            <= `UFD_RST_ZERO8;
            cmin_lo            <= `UFD_RST_ZERO8;
            rdiv_hi            <= 2'h0;
            rdiv_lo            <= `UFD_RST_ZERO8;
            fdiv_hi            <= 7'h00;
            fdiv_lo            <= `UFD_RST_ZERO8;
            pump               <= `UFD_RST_ZERO8;
            lpf_hi             <= 5'h00;
            lpf_lo             <= `UFD_RST_ZERO8;
            usr_afs            <= `UFD_RST_ZERO8;
        end else begin
            if (hit(`UFD_OFF_AUD_FSEQ)) audio_frame_seq <= reg_wdata;
            if (hit(`UFD_OFF_AUD_CLKSEL))
                audio_clock_select <= reg_wdata[3:0];
            if (hit(`UFD_OFF_CMAX_HI)) cmax_hi <= reg_wdata;
            if (hit(`UFD_OFF_CMAX_LO)) cmax_lo <= reg_wdata;
            if (hit(`UFD_OFF_CMIN_HI)) cmin_hi <= reg_wdata;
            if (hit(`UFD_OFF_CMIN_LO)) cmin_lo <= reg_wdata;
            if (hit(`UFD_OFF_RDIV_HI)) rdiv_hi <= reg_wdata[1:0];
            if (hit(`UFD_OFF_RDIV_LO)) rdiv_lo <= reg_wdata;
            if (hit(`UFD_OFF_FDIV_HI)) fdiv_hi <= reg_wdata[6:0];
            if (hit(`UFD_OFF_FDIV_LO)) fdiv_lo <= reg_wdata;
            if (hit(`UFD_OFF_PUMP)) pump <= reg_wdata;
            if (hit(`UFD_OFF_LPF_HI)) lpf_hi <= reg_wdata[4:0];
            if (hit(`UFD_OFF_LPF_LO)) lpf_lo <= reg_wdata;
            if (hit(`UFD_OFF_USR_AFS)) usr_afs <= reg_wdata;
        end
    end

    // Misc register kept apart: its fields steer detection and lookup
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            user_mode_enable    <= 1'b0;
            user_interlace_flag <= 1'b0;
            user_vsync_code     <= 4'h0;
        end else if (hit(`UFD_OFF_MISC)) begin
            user_mode_enable    <= reg_wdata[`UFD_MISC_EN_BIT];
            user_interlace_flag <= reg_wdata[`UFD_MISC_ILACE_BIT];
            user_vsync_code <= reg_wdata[`UFD_MISC_CODE_HI:`UFD_MISC_CODE_LO];
        end
    end

    // ----------------------------------------
    // Frame 3 reset count
    // ----------------------------------------
    // Read-only to software: only the format load moves it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            f3_rst_hi <= `UFD_RST_F3_HI;
            f3_rst_lo <= `UFD_RST_F3_LO;
        end else if (fmt_load) begin
            f3_rst_hi <= fmt_frame3_reset[12:8];
            f3_rst_lo <= fmt_frame3_reset[7:0];
        end
    end

    assign frame3_reset_count = {f3_rst_hi, f3_rst_lo};

    // ----------------------------------------
    // User format detection
    // ----------------------------------------
    wire below_max   = (meas_count <= user_count_max);
    wire above_min   = (meas_count >= user_count_min);
    wire ilace_match = (input_interlaced == user_interlace_flag);
    wire criteria_ok = below_max && above_min && ilace_match;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            user_format_detected <= 1'b0;
            hsync_meas_count     <= 16'h0000;
        end else begin
            if (!user_mode_enable)
                user_format_detected <= 1'b0;
            else if (meas_valid)
                user_format_detected <= criteria_ok;
            if (meas_valid) hsync_meas_count <= meas_count;
        end
    end

    // ----------------------------------------
    // Format lookup outputs
    // ----------------------------------------
    wire user_selected = (input_format_select == USER_CODE[FMT_SEL_W-1:0]);
    wire       next_lut_ilace = user_selected ? user_interlace_flag
                                              : fmt_interlaced;
    wire [3:0] next_vs_code   = user_selected ? user_vsync_code
                                              : fmt_vsync_code;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lut_interlaced     <= 1'b0;
            input_vsync_code   <= 4'h0;
            input_rate_centihz <= 14'd0;
        end else begin
            lut_interlaced     <= next_lut_ilace;
            input_vsync_code   <= next_vs_code;
            input_rate_centihz <= rate_of(next_vs_code);
        end
    end

    // ----------------------------------------
    // Applied settings
    // ----------------------------------------
    // Swap is registered so all five values change in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pll1_ref_divider       <= 10'h000;
            pll1_fb_divider        <= 15'h0000;
            pll1_pump_current      <= 8'h00;
            top_of_frame_lines     <= 13'h0000;
            top_of_frame_audio_seq <= 8'h00;
        end else if (user_format_detected) begin
            pll1_ref_divider       <= {rdiv_hi, rdiv_lo};
            pll1_fb_divider        <= {fdiv_hi, fdiv_lo};
            pll1_pump_current      <= pump;
            top_of_frame_lines     <= {lpf_hi, lpf_lo};
            top_of_frame_audio_seq <= usr_afs;
        end else begin
            pll1_ref_divider       <= fmt_ref_divider;
            pll1_fb_divider        <= fmt_fb_divider;
            pll1_pump_current      <= fmt_pump_current;
            top_of_frame_lines     <= fmt_lines_per_frame;
            top_of_frame_audio_seq <= fmt_audio_frame_seq;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Reserved and unmapped offsets read zero; reads have no side effect
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            `UFD_OFF_F3_RST_HI:  rd_mux = {3'b000, f3_rst_hi};
            `UFD_OFF_F3_RST_LO:  rd_mux = f3_rst_lo;
            `UFD_OFF_AUD_FSEQ:   rd_mux = audio_frame_seq;
            `UFD_OFF_AUD_CLKSEL: rd_mux = {4'h0, audio_clock_select};
            `UFD_OFF_CMAX_HI:    rd_mux = cmax_hi;
            `UFD_OFF_CMAX_LO:    rd_mux = cmax_lo;
            `UFD_OFF_CMIN_HI:    rd_mux = cmin_hi;
            `UFD_OFF_CMIN_LO:    rd_mux = cmin_lo;
            `UFD_OFF_RDIV_HI:    rd_mux = {6'h00, rdiv_hi};
            `UFD_OFF_RDIV_LO:    rd_mux = rdiv_lo;
            `UFD_OFF_FDIV_HI:    rd_mux = {1'b0, fdiv_hi};
            `UFD_OFF_FDIV_LO:    rd_mux = fdiv_lo;
            `UFD_OFF_PUMP:       rd_mux = pump;
            `UFD_OFF_LPF_HI:     rd_mux = {3'b000, lpf_hi};
            `UFD_OFF_LPF_LO:     rd_mux = lpf_lo;
            `UFD_OFF_USR_AFS:    rd_mux = usr_afs;
            `UFD_OFF_MISC:       rd_mux = misc_value;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
            reg_rdata <= rd_mux;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence meas_in_window;
        meas_valid && user_mode_enable
        && meas_count <= user_count_max && meas_count >= user_count_min;
    endsequence

    sequence detect_next;
        ##1 user_format_detected;
    endsequence

    upper_bound_a: assert property (
        meas_valid && user_mode_enable && meas_count > user_count_max
        |=> !user_format_detected)
        else $error("count above upper bound was accepted");

    lower_bound_a: assert property (
        meas_valid && user_mode_enable && meas_count < user_count_min
        |=> !user_format_detected)
        else $error("count below lower bound was accepted");

    enable_gate_a: assert property (
        !user_mode_enable |=> !user_format_detected)
        else $error("detection active while user mode disabled");

    lut_interlace_a: assert property (
        user_selected && !(reg_wr_en && reg_addr == `UFD_OFF_MISC)
        |=> lut_interlaced == user_interlace_flag)
        else $error("lookup interlace differs from user flag");

    interlace_match_a: assert property (
        meas_in_window |-> if (input_interlaced == user_interlace_flag)
                               detect_next
                           else ##1 !user_format_detected)
        else $error("detection disagrees with interlace match");

    vsync_code_a: assert property (
        user_selected && !(reg_wr_en && reg_addr == `UFD_OFF_MISC)
        |=> input_vsync_code == user_vsync_code)
        else $error("lookup vsync code differs from user field");

    frame3_readonly_a: assert property (
        !fmt_load |=> $stable(frame3_reset_count))
        else $error("frame 3 reset count moved without format load");

    audio_write_a: assert property (
        reg_wr_en && reg_addr == `UFD_OFF_AUD_FSEQ
        |=> audio_frame_seq == $past(reg_wdata))
        else $error("audio frame sequence write lost");

    rate_map_a: assert property (
        next_vs_code > `UFD_VS_CODE_LAST |=> input_rate_centihz == 14'd0)
        else $error("unassigned vsync code gave a rate");

    apply_user_a: assert property (
        user_format_detected && !(reg_wr_en && reg_addr == `UFD_OFF_PUMP)
        |=> pll1_pump_current == pump)
        else $error("user pump current not applied");

endmodule
`default_nettype wire

// ### user_format_detect_regs_tb.sv
// Self-checking bench for the user format detect register bank.
// Assumes ufd_regs with default parameters and ufd_map.svh on the path.
`timescale 1ns/1ps
`default_nettype none
module user_format_detect_regs_tb;
    logic        core_clk = 0, arst_n = 0, ref27_pin = 0, hsync_pin = 0;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, d;
    logic        reg_wr_en = 0, reg_rd_en = 0, fmt_load = 0;
    logic        input_interlaced = 0, fmt_interlaced = 0;
    logic [4:0]  input_format_select = 0;
    logic [3:0]  fmt_vsync_code = 0, input_vsync_code;
    logic [12:0] fmt_frame3_reset = 0, fmt_lines_per_frame = 0, f3;
    logic [9:0]  fmt_ref_divider = 0, pll1_ref_divider;
    logic [14:0] fdiv;
    logic [12:0] lines;
    logic [7:0]  afs, pump, aseq, wv [96];
    logic [3:0]  acs;
    logic [15:0] ufb, ulp;
    logic        u;
    logic [14:0] fmt_fb_divider = 0;
    logic [7:0]  fmt_pump_current = 0, fmt_audio_frame_seq = 0;
    logic        lut_interlaced, user_format_detected;
    ufd_pkg::ufd_rate_t  input_rate_centihz;
    ufd_pkg::ufd_count_t hsync_meas_count;
    int          n_errors = 0, tests_run = 0, i;
    integer      seed = 32'h133d8d8c;
    // ------------------------------------------------------------------
    // Clocks and pins: hsync period 1 us gives about 540 counts a window
    // ------------------------------------------------------------------
    initial forever #2.5 core_clk = ~core_clk;
    initial forever #18.518 ref27_pin = ~ref27_pin;
    initial forever begin #900 hsync_pin = 1; #100 hsync_pin = 0; end
    ufd_regs u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata), .ref27_pin(ref27_pin), .hsync_pin(hsync_pin),
        .input_interlaced(input_interlaced),
        .input_format_select(input_format_select),
        .fmt_interlaced(fmt_interlaced), .fmt_vsync_code(fmt_vsync_code),
        .fmt_load(fmt_load), .fmt_frame3_reset(fmt_frame3_reset),
        .fmt_ref_divider(fmt_ref_divider), .fmt_fb_divider(fmt_fb_divider),
        .fmt_pump_current(fmt_pump_current),
        .fmt_lines_per_frame(fmt_lines_per_frame),
        .fmt_audio_frame_seq(fmt_audio_frame_seq),
        .lut_interlaced(lut_interlaced), .input_vsync_code(input_vsync_code),
        .input_rate_centihz(input_rate_centihz),
        .user_format_detected(user_format_detected),
        .hsync_meas_count(hsync_meas_count),
        .frame3_reset_count(f3), .audio_frame_seq(afs),
        .audio_clock_select(acs), .pll1_ref_divider(pll1_ref_divider),
        .pll1_fb_divider(fdiv), .pll1_pump_current(pump),
        .top_of_frame_lines(lines), .top_of_frame_audio_seq(aseq));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            8'h48: rst_val = 8'h01;
            8'h49: rst_val = 8'h05;
            8'h4a: rst_val = 8'h0b;
            default: rst_val = 8'h00;
        endcase
    endfunction
    // Writable bits; zero means writes are dropped
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h4a: msk = 8'h0f;
            8'h55: msk = 8'h03;
            8'h57: msk = 8'h7f;
            8'h5a: msk = 8'h1f;
            8'h5d: msk = 8'h9f;
            8'h49, 8'h51, 8'h52, 8'h53, 8'h54, 8'h56, 8'h58, 8'h59,
            8'h5b, 8'h5c: msk = 8'hff;
            default: msk = 8'h00;
        endcase
    endfunction
    function automatic logic [13:0] rate(input logic [3:0] c);
        logic [13:0] t [8] = '{14'd2398, 14'd2400, 14'd2500, 14'd2997,
                               14'd3000, 14'd5000, 14'd5994, 14'd6000};
        rate = c[3] ? 14'd0 : t[c[2:0]];
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge core_clk); reg_addr <= a; reg_wdata <= v; reg_wr_en <= 1;
        @(posedge core_clk); reg_wr_en <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk); reg_addr <= a; reg_rd_en <= 1;
        @(posedge core_clk); reg_rd_en <= 0;
        #1 v = reg_rdata;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    logic [7:0] sa [8] = '{8'h5d, 8'h5d, 8'h5d, 8'h52, 8'h52, 8'h54, 8'h54,
                           8'h5d};
    logic [7:0] sd [8] = '{8'h90, 8'h90, 8'h90, 8'h00, 8'h26, 8'h58, 8'h12,
                           8'h10};
    logic [7:0] sv [8] = '{8'h11, 8'h00, 8'h11, 8'h10, 8'h11, 8'h10, 8'h11,
                           8'h10};
    logic [9:0] urd;
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1;
        fmt_ref_divider <= $random(seed);
        fmt_interlaced <= 1;
        fmt_vsync_code <= $random(seed);
        chk("afs reset", 8'h05, afs);
        chk("aclk reset", 4'hb, acs);
        for (i = 8'h45; i < 8'h60; i++) begin
            rd(i[7:0], d); chk("reset value", rst_val(i[7:0]), d);
            reg_wdata <= 8'h00;
            wr(i[7:0], $random(seed) & 8'hff);
            wv[i] = reg_wdata & msk(i[7:0]);
            rd(i[7:0], d);
            chk("readback", msk(i[7:0]) == 0 ? rst_val(i[7:0])
                : reg_wdata & msk(i[7:0]), d);
        end
        chk("builtin ilace", fmt_interlaced, lut_interlaced);
        chk("builtin code", fmt_vsync_code, input_vsync_code);
        chk("afs out", wv[8'h49], afs);
        chk("aclk out", wv[8'h4a], acs);
        @(posedge core_clk); fmt_frame3_reset <= $random(seed); fmt_load <= 1;
        @(posedge core_clk); fmt_load <= 0;
        rd(8'h47, d); chk("f3 high", fmt_frame3_reset[12:8], d);
        rd(8'h48, d); chk("f3 low", fmt_frame3_reset[7:0], d);
        chk("f3 out", fmt_frame3_reset, f3);
        input_format_select <= 5'h1f;
        for (i = 0; i < 16; i++) begin
            wr(8'h5d, {3'b000, i[0], i[3:0]}); repeat (3) @(posedge core_clk);
            chk("lut ilace", i[0], lut_interlaced);
            chk("lut code", i[3:0], input_vsync_code);
            chk("rate", rate(i[3:0]), input_rate_centihz);
        end
        // Window near 540 counts: bounds 530..550, then moved across it
        wr(8'h51, 8'h02); wr(8'h52, 8'h26);
        wr(8'h53, 8'h02); wr(8'h54, 8'h12);
        urd = $random(seed);
        wr(8'h55, {6'h00, urd[9:8]}); wr(8'h56, urd[7:0]);
        ufb = {wv[8'h57], wv[8'h58]};
        ulp = {wv[8'h5a], wv[8'h5b]};
        for (i = 0; i < 8; i++) begin
            wr(sa[i], sd[i]); input_interlaced <= sv[i][4];
            u = sv[i][0];
            for (int k = 0; k < 12000 && user_format_detected !== sv[i][0];
                 k++) @(posedge core_clk);
            repeat (3) @(posedge core_clk);
            chk("detected", sv[i][0], user_format_detected);
            chk("ref div", sv[i][0] ? urd : fmt_ref_divider,
                pll1_ref_divider);
            chk("pump", u ? wv[8'h59] : fmt_pump_current, pump);
            chk("fdiv", u ? ufb : fmt_fb_divider, fdiv);
            chk("lines", u ? ulp : fmt_lines_per_frame, lines);
            chk("aseq", u ? wv[8'h5c] : fmt_audio_frame_seq, aseq);
        end
        chk("meas range", 1, hsync_meas_count inside {[530:550]});
        give_verdict();
    end
endmodule
`default_nettype wire
